/* hbd_pkg.sv */
`default_nettype none
package hbd_pkg;
    // register byte offsets, one aligned word each, index equals read select code
    localparam logic [7:0] OFF_VEC = 8'h00;
    localparam logic [7:0] OFF_LDB = 8'h04;
    localparam logic [7:0] OFF_ICR = 8'h08;
    localparam logic [7:0] OFF_BSR = 8'h0C;
    localparam logic [7:0] OFF_BCR = 8'h10;
    localparam logic [7:0] OFF_ISR = 8'h14;
    localparam logic [7:0] OFF_CTR = 8'h18;
    localparam logic [7:0] OFF_BAR = 8'h1C;
    // read select codes
    localparam logic [2:0] SEL_VEC = 3'h0;
    localparam logic [2:0] SEL_LDB = 3'h1;
    localparam logic [2:0] SEL_ICR = 3'h2;
    localparam logic [2:0] SEL_BSR = 3'h3;
    localparam logic [2:0] SEL_BCR = 3'h4;
    localparam logic [2:0] SEL_ISR = 3'h5;
    localparam logic [2:0] SEL_CTR = 3'h6;
    localparam logic [2:0] SEL_BAR = 3'h7;
    // field positions
    // full flag sits above bits 10:8, which only count and address may drive
    localparam int ICR_FULL_BIT = 11;
    localparam int BCR_GO_BIT = 0;
    localparam int BCR_BURST_BIT = 1;
    localparam int BCR_REPL_BIT = 2;
    localparam int BCR_LISTEN_BIT = 3;
    localparam int BCR_DONE_BIT = 4;
    localparam int SRC_LAST_BYTE = 6;
    localparam logic [2:0] CODE_LAST_BYTE = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing: bus give-up time in burst mode
    localparam int CLK_MHZ = 50;
    localparam int GIVEUP_US = 20;
    localparam int GIVEUP_CYC = GIVEUP_US * CLK_MHZ;
    typedef enum logic [3:0] {
        ST_IRQ_CHK = 4'h0, ST_IRQ_CHK2 = 4'h1, ST_WAIT_BUS = 4'h2, ST_VECTOR = 4'h3,
        ST_INTR = 4'h4, ST_IRQ_DONE = 4'h5, ST_IDLE = 4'h6, ST_OWN_CHK = 4'h7,
        ST_REQ = 4'h8, ST_ACK = 4'h9, ST_XFER = 4'hA, ST_XFER_END = 4'hB,
        ST_COUNT = 4'hC, ST_SPARE13 = 4'hD, ST_SPARE14 = 4'hE, ST_SPARE15 = 4'hF
    } hbd_state_e;
    // microcode word: branch target, wait(1)/branch(0), interrupt reset enable
    typedef struct packed {
        logic [3:0] nxt;
        logic wait_mode;
        logic rst_en;
    } hbd_uword_s;
    localparam hbd_uword_s UCODE [16] = '{
        '{4'h6, 1'b0, 1'b0}, '{4'h0, 1'b0, 1'b0}, '{4'h0, 1'b1, 1'b0}, '{4'h0, 1'b1, 1'b0},
        '{4'h0, 1'b1, 1'b0}, '{4'h6, 1'b0, 1'b1}, '{4'h0, 1'b1, 1'b1}, '{4'hA, 1'b0, 1'b1},
        '{4'h0, 1'b1, 1'b1}, '{4'h0, 1'b1, 1'b0}, '{4'h0, 1'b1, 1'b0}, '{4'h0, 1'b1, 1'b0},
        '{4'h6, 1'b0, 1'b0}, '{4'h6, 1'b0, 1'b0}, '{4'h6, 1'b0, 1'b0}, '{4'h6, 1'b0, 1'b0}
    };
endpackage : hbd_pkg
`default_nettype wire

/* hbd_top.sv */
// Function
// - read select code picks one of eight sources
// - bit 8 blank, status bits 9-12 write-only
// - bits 8-10 only from count or address
// - byte replicate mirrors low byte onto high
// - DMA buffer read without replicate forces bits 12-15 zero
// - eight interrupt sources handled identically
// - end interrupt needs seen flag and enable
// - seen flag set by DAV, EOI, no ATN
// - pending is OR of synchronised enabled sources
// - latch pending, priority encode, end is 110
// - vector is user bits, code, two zeros
// - issued source blocked until condition recurs
// - burst mode gives bus up after 20us
// - NPR, NPG, SACK, then BBSY when free
// - granted interrupt acts only at cycle boundary
// - sixteen states, microcode gives next and mode
// - per-state condition; wait flag stalls, else branches
// - step clock low while waiting, high latches
// - direction input high listening, low talking
// - register access or INIT clears state
// - granted interrupt resets only in states 5-8
// - buffer read clears listener full flag
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
module hbd_top
    import hbd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic init,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic dav_i,
    input wire logic eoi_i,
    input wire logic atn_i,
    input wire logic lb_valid_i,
    input wire logic [15:0] lb_data_i,
    input wire logic [7:0] src_evt_i,
    input wire logic npg_i,
    input wire logic bg_i,
    input wire logic ssyn_i,
    input wire logic bbsy_i,
    output logic bbsy_o,
    output logic bbsy_oe,
    output logic npr_o,
    output logic sack_o,
    output logic br_o,
    output logic intr_o,
    output logic byte_o,
    output logic [15:0] host_data_o,
    output logic host_data_oe,
    output logic [15:0] host_addr_o,
    output logic irq_pending_o,
    output logic step_clk_o,
    output logic [15:0] state_strobe_o
);
    logic aw_hold_reg, w_hold_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire, rd_fire, acc;
    logic [2:0] vector_bit_reg;
    logic [7:0] irq_en_reg, isr_reg, blk_reg, sync1_reg, sync2_reg;
    logic listener_full_reg;
    logic [15:0] ldb_reg, ctr_reg, bar_reg;
    logic [4:0] bcr_reg;
    logic [3:0] wo_ctrl_reg;
    logic [7:0] vec_reg;
    logic [7:0] pend_lat_reg;
    logic [3:0] state_reg;
    logic step_reg;
    logic sack_irq_reg, bus_own_reg;
    logic [9:0] giveup_cnt_reg;
    logic [7:0] pend;
    logic [15:0] cond;
    hbd_uword_s uw;
    logic advance, force_irq, giveup_hit, leave_wait_bus;
    logic [3:0] target;
    logic [15:0] rd_val;
    logic [2:0] rd_sel;
    logic ldb_host_read, dma_ldb_read;

    // merge a 16-bit register with the low two byte lanes of a write
    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0]) r[7:0] = d[7:0];
        if (s[1]) r[15:8] = d[15:8];
        return r;
    endfunction : wmerge

    // eight-to-three encoder, highest source wins
    function automatic logic [2:0] prio8(input logic [7:0] p);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (p[i]) c = 3'(i);
        end
        return c;
    endfunction : prio8

    // axi write: address and data taken in either order, response after both
    assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_reg <= 1'b0;
            end
            // ready held low while a word is parked, one write at a time
            s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready);
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_reg[ADDR_W-1:5] != '0) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read: one beat, data registered with the answer
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_sel = s_axi_araddr[4:2];
    always_comb begin
        case (rd_sel)
            SEL_VEC: rd_val = {8'h00, vec_reg};
            SEL_LDB: rd_val = ldb_reg;
            SEL_ICR: rd_val = {4'h0, listener_full_reg, 3'h0, irq_en_reg};
            SEL_BSR: rd_val = {8'h00, bus_own_reg, step_reg, 2'h0, state_reg};
            SEL_BCR: rd_val = {11'h000, bcr_reg};
            SEL_ISR: rd_val = {8'h00, isr_reg};
            SEL_CTR: rd_val = ctr_reg;
            default: rd_val = bar_reg;
        endcase
        // bits 8-10 steered only for count or address reads
        if (rd_sel != SEL_CTR && rd_sel != SEL_BAR) begin
            rd_val[10:8] = 3'h0;
        end
        if (rd_sel == SEL_BSR) begin
            rd_val[12:9] = 4'h0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                if (s_axi_araddr[ADDR_W-1:5] != '0) begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end else begin
                    s_axi_rdata <= {16'h0000, rd_val};
                    s_axi_rresp <= RESP_OKAY;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign ldb_host_read = rd_fire && s_axi_araddr == ADDR_W'(OFF_LDB);
    assign acc = wr_fire || rd_fire;

    // software registers; the sequencer bumps count and address after each transfer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            vector_bit_reg <= 3'h0;
            irq_en_reg <= 8'h00;
            bcr_reg <= 5'h00;
            wo_ctrl_reg <= 4'h0;
            ctr_reg <= 16'h0000;
            bar_reg <= 16'h0000;
        end else if (wr_fire && aw_addr_reg[ADDR_W-1:5] == '0) begin
            case (aw_addr_reg[4:2])
                SEL_VEC: vector_bit_reg <= w_data_reg[7:5];
                SEL_ICR: irq_en_reg <= 8'(wmerge({8'h00, irq_en_reg}, w_data_reg, w_strb_reg));
                SEL_BSR: wo_ctrl_reg <= 4'(wmerge(16'h0000, w_data_reg, w_strb_reg) >> 9);
                SEL_BCR: bcr_reg <= 5'(wmerge({11'h000, bcr_reg}, w_data_reg, w_strb_reg));
                SEL_CTR: ctr_reg <= wmerge(ctr_reg, w_data_reg, w_strb_reg);
                SEL_BAR: bar_reg <= wmerge(bar_reg, w_data_reg, w_strb_reg);
                default: ;
            endcase
        end else if (step_reg && state_reg == ST_COUNT) begin
            ctr_reg <= ctr_reg + 16'h0001;
            bar_reg <= bar_reg + (bcr_reg[BCR_REPL_BIT] ? 16'h0001 : 16'h0002);
        end
    end

    // listener buffer; a new byte or a host read, the set wins over the clear
    assign dma_ldb_read = step_reg && state_reg == ST_XFER && bcr_reg[BCR_LISTEN_BIT];
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ldb_reg <= 16'h0000;
            listener_full_reg <= 1'b0;
        end else if (lb_valid_i && !listener_full_reg) begin
            ldb_reg <= lb_data_i;
            listener_full_reg <= 1'b1;
        end else if (ldb_host_read || dma_ldb_read) begin
            listener_full_reg <= 1'b0;
        end
    end

    // per-source sticky flag, request synchroniser and re-arm block
    generate
        for (genvar i = 0; i < 8; i++) begin : g_src
            logic evt;
            if (i == SRC_LAST_BYTE) begin : g_end
                assign evt = dav_i && eoi_i && !atn_i;
            end else begin : g_oth
                assign evt = src_evt_i[i];
            end
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    isr_reg[i] <= 1'b0;
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                    blk_reg[i] <= 1'b0;
                end else begin
                    if (evt) begin
                        isr_reg[i] <= 1'b1;
                    end else if (wr_fire && aw_addr_reg == ADDR_W'(OFF_ISR)
                                 && w_strb_reg[0] && w_data_reg[i]) begin
                        isr_reg[i] <= 1'b0;
                    end
                    sync1_reg[i] <= isr_reg[i] && irq_en_reg[i];
                    sync2_reg[i] <= sync1_reg[i];
                    // issued source stays silent until its condition drops
                    if (step_reg && state_reg == ST_VECTOR && prio8(pend_lat_reg) == 3'(i)) begin
                        blk_reg[i] <= 1'b1;
                    end else if (!sync2_reg[i]) begin
                        blk_reg[i] <= 1'b0;
                    end
                end
            end
            assign pend[i] = sync2_reg[i] && !blk_reg[i];
        end
    endgenerate

    // condition per state; index is the current state
    always_comb begin
        cond = 16'h0000;
        cond[ST_IRQ_CHK] = !sack_irq_reg;
        cond[ST_IRQ_CHK2] = !sack_irq_reg;
        cond[ST_WAIT_BUS] = bbsy_i && !bus_own_reg;
        cond[ST_VECTOR] = ssyn_i;
        cond[ST_INTR] = !ssyn_i;
        cond[ST_IDLE] = !(bcr_reg[BCR_GO_BIT] && (bcr_reg[BCR_LISTEN_BIT] ?
                          listener_full_reg : bcr_reg[BCR_DONE_BIT]));
        cond[ST_OWN_CHK] = bus_own_reg;
        cond[ST_REQ] = !npg_i;
        cond[ST_ACK] = npg_i || bbsy_i;
        cond[ST_XFER] = !ssyn_i;
        cond[ST_XFER_END] = ssyn_i;
        cond[ST_COUNT] = 1'b1;
        cond[ST_SPARE13] = 1'b1;
        cond[ST_SPARE14] = 1'b1;
        cond[ST_SPARE15] = 1'b1;
    end

    assign uw = UCODE[state_reg];
    assign advance = !(uw.wait_mode && cond[state_reg]);
    assign target = (!uw.wait_mode && cond[state_reg]) ? uw.nxt : state_reg + 4'h1;
    assign force_irq = uw.rst_en && sack_irq_reg;
    assign giveup_hit = bcr_reg[BCR_BURST_BIT] && giveup_cnt_reg == 10'(GIVEUP_CYC - 1);
    assign leave_wait_bus = !step_reg && state_reg == ST_WAIT_BUS && advance;

    // sequencer state and internal step clock
    always_ff @(posedge core_clk) begin
        if (rst || init || acc) begin
            state_reg <= ST_IRQ_CHK;
            step_reg <= 1'b0;
        end else if (step_reg) begin
            step_reg <= 1'b0; // decoders enabled again
        end else if (force_irq) begin
            state_reg <= ST_IRQ_CHK;
            step_reg <= 1'b1;
        end else if (giveup_hit) begin
            state_reg <= ST_IDLE;
            step_reg <= 1'b1;
        end else if (advance) begin
            state_reg <= target;
            step_reg <= 1'b1;
        end
    end

    // no-response timer while this end waits on the host bus
    always_ff @(posedge core_clk) begin
        if (rst || step_reg || (state_reg != ST_XFER && state_reg != ST_XFER_END)) begin
            giveup_cnt_reg <= 10'h000;
        end else if (!giveup_hit) begin
            giveup_cnt_reg <= giveup_cnt_reg + 10'h001;
        end
    end

    // interrupt latch and vector
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend_lat_reg <= 8'h00;
            vec_reg <= 8'h00;
            irq_pending_o <= 1'b0;
        end else begin
            irq_pending_o <= |pend;
            if (leave_wait_bus) begin
                pend_lat_reg <= pend;
                vec_reg <= {vector_bit_reg, prio8(pend), 2'h0};
            end
        end
    end

    // host-bus arbitration and data drive
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sack_irq_reg <= 1'b0;
            bus_own_reg <= 1'b0;
            br_o <= 1'b0;
            npr_o <= 1'b0;
            sack_o <= 1'b0;
            intr_o <= 1'b0;
            bbsy_o <= 1'b0;
            bbsy_oe <= 1'b0;
            byte_o <= 1'b0;
            host_data_o <= 16'h0000;
            host_data_oe <= 1'b0;
            host_addr_o <= 16'h0000;
            step_clk_o <= 1'b0;
        end else begin
            step_clk_o <= step_reg;
            br_o <= (|pend) && !sack_irq_reg && state_reg != ST_VECTOR;
            if (br_o && bg_i) begin
                sack_irq_reg <= 1'b1;
            end else if (step_reg && state_reg == ST_INTR) begin
                sack_irq_reg <= 1'b0;
            end
            npr_o <= state_reg == ST_REQ;
            sack_o <= sack_irq_reg || state_reg == ST_ACK;
            intr_o <= state_reg == ST_INTR && !step_reg;
            if (step_reg && (state_reg == ST_VECTOR || state_reg == ST_XFER)) begin
                bus_own_reg <= 1'b1;
            end else if (giveup_hit || (step_reg && (state_reg == ST_IRQ_DONE
                         || (state_reg == ST_IDLE && !bcr_reg[BCR_BURST_BIT])))) begin
                bus_own_reg <= 1'b0; // non-burst shares every cycle
            end
            bbsy_o <= bus_own_reg;
            bbsy_oe <= bus_own_reg;
            host_addr_o <= bar_reg;
            if (step_reg && state_reg == ST_VECTOR) begin
                host_data_o <= {8'h00, vec_reg};
                host_data_oe <= 1'b1;
                byte_o <= 1'b0;
            end else if (dma_ldb_read) begin
                host_data_oe <= 1'b1;
                byte_o <= bcr_reg[BCR_REPL_BIT];
                if (bcr_reg[BCR_REPL_BIT]) begin
                    host_data_o <= {ldb_reg[7:0], ldb_reg[7:0]};
                end else begin
                    host_data_o <= {4'h0, ldb_reg[11:0]};
                end
            end else if (step_reg && (state_reg == ST_IRQ_DONE || state_reg == ST_COUNT)) begin
                host_data_oe <= 1'b0;
                byte_o <= 1'b0;
            end
        end
    end

    // one-hot decoder strobes, enabled only while the step clock is low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_strobe_o <= 16'h0000;
        end else begin
            state_strobe_o <= !step_reg ? (16'h0001 << state_reg) : 16'h0000;
        end
    end

    sequence s_access;
        acc && !rst;
    endsequence
    sequence s_ldb_dma;
        dma_ldb_read;
    endsequence

    a_access_clears_state: assert property (@(posedge core_clk) disable iff (rst)
        s_access |=> state_reg == ST_IRQ_CHK && !step_reg)
        else $error("state not cleared by register access");
    a_force_window: assert property (@(posedge core_clk) disable iff (rst)
        (!step_reg && sack_irq_reg && !acc && !init && state_reg inside {[4'h5:4'h8]})
        |=> state_reg == ST_IRQ_CHK && step_reg)
        else $error("granted interrupt did not reset sequencer");
    a_zero_high_nib: assert property (@(posedge core_clk) disable iff (rst)
        s_ldb_dma and !bcr_reg[BCR_REPL_BIT] |=> host_data_o[15:12] == 4'h0 && host_data_oe)
        else $error("dma buffer word high bits not zero");
    a_byte_mirror: assert property (@(posedge core_clk) disable iff (rst)
        s_ldb_dma and bcr_reg[BCR_REPL_BIT] |=> host_data_o[15:8] == host_data_o[7:0] && byte_o)
        else $error("byte lanes not mirrored");
    a_step_pulse: assert property (@(posedge core_clk) disable iff (rst)
        step_reg |=> !step_reg)
        else $error("step clock held high");
    a_strobe_onehot: assert property (@(posedge core_clk) disable iff (rst)
        !step_reg |=> $onehot(state_strobe_o) && state_strobe_o[$past(state_reg)])
        else $error("state strobe not one-hot");
    a_vector_form: assert property (@(posedge core_clk) disable iff (rst)
        leave_wait_bus |=> vec_reg[1:0] == 2'h0 && vec_reg[7:5] == $past(vector_bit_reg))
        else $error("vector layout wrong");
    a_last_byte_set: assert property (@(posedge core_clk) disable iff (rst)
        dav_i && eoi_i && !atn_i |=> isr_reg[SRC_LAST_BYTE])
        else $error("last byte flag not set");
    a_full_cleared: assert property (@(posedge core_clk) disable iff (rst)
        ldb_host_read && !(lb_valid_i && !listener_full_reg) |=> !listener_full_reg)
        else $error("listener full not cleared on read");
    a_pend_or: assert property (@(posedge core_clk) disable iff (rst)
        ##1 irq_pending_o == ($past(pend) != 8'h00))
        else $error("pending output not the or of sources");
endmodule : hbd_top
`default_nettype wire

/* hbd_host_model.sv */
`default_nettype none
module hbd_host_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic npr_o,
    input wire logic sack_o,
    input wire logic br_o,
    input wire logic intr_o,
    input wire logic bbsy_oe,
    input wire logic host_data_oe,
    output logic npg_i,
    output logic bg_i,
    output logic ssyn_i,
    output logic bbsy_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ssyn_dly, oe_q, dma_q;
    // arbiter grants while requested, withdraws once acknowledged
    always_ff @(posedge core_clk) begin
        npg_i <= !rst && npr_o && !sack_o;
        bg_i <= !rst && br_o && !sack_o;
    end
    // processor takes the vector two cycles late; memory answers one dma word with a pulse,
    // only after a dma grant so the vector drive is not mistaken for a data cycle
    always_ff @(posedge core_clk) begin
        oe_q <= host_data_oe;
        dma_q <= !rst && (npg_i || (dma_q && !bg_i));
        ssyn_dly <= !rst && (intr_o || (dma_q && host_data_oe && !oe_q));
        ssyn_i <= !rst && ssyn_dly;
    end
    // no other master here, so the wire follows our own enable
    assign bbsy_i = bbsy_oe;
endmodule : hbd_host_model
`default_nettype wire

/* host_bus_irq_dma_sequencer_tb.sv */
`default_nettype none
module host_bus_irq_dma_sequencer_tb;
    import hbd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, init, awv, wv, bre, arv, rre, dav, eoi, atn, lbv;
    logic awr, wr, bv, arr, rv, npr, sack, br, intr, bo, boe, npg, bg, ssyn, bbi, irq;
    logic [7:0] awa, ara, evt;
    logic [31:0] wd, rd, got;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] lbd, strb, hd;
    logic hdoe, byt;
    int n_errors = 0, checks = 0, seed = 32'hdc97, i;
    hbd_top i_dut (.core_clk(core_clk), .rst(rst), .init(init), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .dav_i(dav), .eoi_i(eoi), .atn_i(atn), .lb_valid_i(lbv), .lb_data_i(lbd),
        .src_evt_i(evt), .npg_i(npg), .bg_i(bg), .ssyn_i(ssyn), .bbsy_i(bbi), .bbsy_o(bo),
        .bbsy_oe(boe), .npr_o(npr), .sack_o(sack), .br_o(br), .intr_o(intr), .byte_o(byt),
        .host_data_o(hd), .host_data_oe(hdoe), .host_addr_o(), .irq_pending_o(irq),
        .step_clk_o(), .state_strobe_o(strb));
    hbd_host_model i_host (.core_clk(core_clk), .rst(rst), .npr_o(npr), .sack_o(sack),
        .br_o(br), .intr_o(intr), .bbsy_oe(boe), .host_data_oe(hdoe), .npg_i(npg),
        .bg_i(bg), .ssyn_i(ssyn), .bbsy_i(bbi));
    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic test_done;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bound(input int n);
        if (n >= 200) begin
            n_errors++;
            test_done();
        end
    endtask : bound
    // both channels offered together, each dropped at the edge that takes it;
    // bready and rready stay up between calls so no edge sees them lowered and raised
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
        do begin
            @(posedge core_clk); n++;
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (bv !== 1'b1 && n < 200);
        resp = bresp;
        bound(n);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        ara <= a; arv <= 1; rre <= 1;
        do begin
            @(posedge core_clk); n++;
            if (arr) arv <= 0;
        end while (rv !== 1'b1 && n < 200);
        d = rd;
        resp = rresp;
        bound(n);
    endtask : rd_reg
    // a host read sees bits 10:8 blank, those come only from count or address
    function automatic logic [31:0] ldb_exp(input logic [15:0] v);
        return {16'h0, v[15:11], 3'b000, v[7:0]};
    endfunction : ldb_exp
    task automatic wait_for(ref logic s, input logic lvl);
        int n;
        for (n = 0; n < 200 && s !== lvl; n++) @(posedge core_clk);
        bound(n);
    endtask : wait_for
    initial begin
        {rst, init, awv, wv, bre, arv, rre, dav, eoi, atn, lbv} = 11'h400;
        awa = 0; ara = 0; wd = 0; lbd = 0; evt = 0;
        repeat (8) @(posedge core_clk);
        rst <= 0;
        repeat (20) @(posedge core_clk);
        chk("idle strobe", strb, 16'h0040);
        init <= 1;
        @(posedge core_clk) init <= 0;
        repeat (20) @(posedge core_clk);
        chk("init idle", strb, 16'h0040);
        wr_reg(8'h20, 32'h0);
        chk("unmapped", resp, RESP_SLVERR);
        wr_reg(OFF_BSR, 32'hFFFF);
        for (i = 0; i < 6; i++) begin
            rd_reg(8'(i * 4), got);
            chk("blank bits", got & 32'hFFFF_0700, 32'h0);
        end
        rd_reg(OFF_BSR, got);
        chk("write only", got[12:9], 4'h0);
        lbd <= 16'($random(seed));
        evt <= 8'($random(seed)) & 8'hBF;
        @(posedge core_clk) lbv <= 1;
        @(posedge core_clk) lbv <= 0;
        rd_reg(OFF_ICR, got);
        chk("full set", got[ICR_FULL_BIT], 1'b1);
        rd_reg(OFF_LDB, got);
        chk("buffer", got, ldb_exp(lbd));
        rd_reg(OFF_ICR, got);
        chk("full clear", got[ICR_FULL_BIT], 1'b0);
        wr_reg(OFF_ISR, 32'hFF);
        dav <= 1; eoi <= 1; atn <= 1;
        repeat (5) @(posedge core_clk);
        rd_reg(OFF_ISR, got);
        chk("atn blocks", got[SRC_LAST_BYTE], 1'b0);
        chk("no irq", irq, 1'b0);
        wr_reg(OFF_VEC, 32'hE0);
        wr_reg(OFF_ICR, 32'h40);
        atn <= 0;
        wait_for(irq, 1'b1);
        wait_for(intr, 1'b1);
        wait_for(intr, 1'b0);
        repeat (10) @(posedge core_clk);
        chk("source blocked", irq, 1'b0);
        rd_reg(OFF_ISR, got);
        chk("end seen", got[SRC_LAST_BYTE], 1'b1);
        rd_reg(OFF_VEC, got);
        chk("vector", got, {24'h0, 3'b111, CODE_LAST_BYTE, 2'b00});
        // listen dma: one word with byte replicate, then one plain word
        for (i = 0; i < 2; i++) begin
            wr_reg(OFF_BCR, i ? 32'h09 : 32'h0D);
            lbd <= 16'($random(seed));
            lbv <= 1;
            @(posedge core_clk) lbv <= 0;
            wait_for(hdoe, 1'b1);
            chk("dma data", hd, i ? {4'h0, lbd[11:0]} : {2{lbd[7:0]}});
            chk("byte line", byt, i == 0);
            wait_for(hdoe, 1'b0);
        end
        dav <= 0; eoi <= 0;
        test_done();
    end
endmodule : host_bus_irq_dma_sequencer_tb
`default_nettype wire
